/* File: hdl/edso_dma_status.sv */
// dma event status, operation mode and process control behind axi4-lite
`default_nettype none
// How it works
// - normal summary ORs enabled normal flags
// - abnormal summary ORs enabled abnormal flags
// - flags sticky, write one clears
// - early receive set, cleared by receive-complete
// - bus error records type, halts engine
// - early transmit when frame in fifo
// - watchdog expiry flags and truncates frame
// - stopped flags on entering stopped
// - host-owned rx descriptor suspends reception
// - rx completion writes status, flags done
// - tx underflow suspends, marks descriptor
// - rx overflow flags, marks descriptor
// - jabber beyond size limit stops transmit
// - host-owned tx descriptor suspends transmit
// - tx completion clears ownership, flags done
// - drop error frames unless forwarding
// - rx store-forward waits for whole frame
// - no-flush setting blocks descriptor flushes
// - tx start on whole frame or threshold
// - threshold codes decode to byte counts
// - tx flush self-clears when done
// - tx start runs, clear stops after frame
// - short frames forwarded, giants optionally dropped
// - bus error type encoding
module edso_dma_status (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transmit engine events
  input wire logic tx_desc_valid,
  input wire logic tx_desc_own,
  input wire logic tx_poll,
  input wire logic tx_frame_in_fifo,
  input wire logic tx_frame_done,
  input wire logic tx_underflow,
  input wire logic [13:0] tx_bytes,
  input wire logic jumbo_en,
  input wire logic [13:0] tx_fifo_bytes,
  input wire logic tx_fifo_flush_done,
  // receive engine events
  input wire logic rx_desc_valid,
  input wire logic rx_desc_own,
  input wire logic rx_poll,
  input wire logic rx_frame_start,
  input wire logic rx_first_buf,
  input wire logic rx_frame_done,
  input wire logic rx_int_disable,
  input wire logic rx_overflow,
  input wire logic rx_watchdog,
  input wire logic rx_fifo_whole,
  input wire logic rx_stat_valid,
  input wire edso_pkg::edso_rxstat_s rx_stat,
  // bus master errors
  input wire edso_pkg::edso_buserr_s bus_err,
  // engine control and descriptor write-back
  output logic tx_bus_en,
  output logic rx_bus_en,
  output logic tx_desc_wr,
  output logic [31:0] tx_desc_word0,
  output logic rx_desc_wr,
  output logic [31:0] rx_desc_word0,
  output logic rx_truncate,
  output logic rx_flush,
  output logic rx_read_en,
  output logic tx_fifo_flush,
  output logic tx_go,
  output logic rx_verdict_valid,
  output logic rx_drop
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [16:0] flags;
    logic [2:0] err_type;
    logic [31:0] opmode;
    logic [16:0] irq_en;
    edso_pkg::edso_proc_e tx_st;
    edso_pkg::edso_proc_e rx_st;
    logic tx_bus_en;
    logic rx_bus_en;
    logic rx_prev_own;
    logic rx_ovf_frame;
    logic tx_wb;
    logic [31:0] tx_word0;
    logic rx_wb;
    logic [31:0] rx_word0;
    logic rx_trunc;
    logic rx_flush;
    logic rx_read_en;
  } edso_regs_s;

  edso_regs_s s;
  edso_regs_s n;
  logic [16:0] set;
  logic [16:0] clr;
  logic [31:0] bm;
  logic aw_hs;
  logic w_hs;
  logic do_wr;
  logic tx_run;
  logic rx_run;
  logic jab;

  always_comb begin
    n = s;
    set = '0;
    clr = '0;
    n.tx_wb = 1'b0;
    n.rx_wb = 1'b0;
    n.rx_trunc = 1'b0;
    n.rx_flush = 1'b0;
    aw_hs = s_axi_awvalid && s.awready;
    w_hs = s_axi_wvalid && s.wready;
    // write channel: address and data may arrive in either order
    if (aw_hs) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    do_wr = n.aw_got && n.w_got && !s.bvalid;
    bm = edso_pkg::lane_mask(n.wstrb);
    if (do_wr) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = edso_pkg::RESP_OKAY;
      case (n.awaddr)
        edso_pkg::A_STATUS: clr = n.wdata[16:0] & bm[16:0] & edso_pkg::W1C;
        edso_pkg::A_OPMODE: begin
          n.opmode = ((s.opmode & ~bm) | (n.wdata & bm)) & edso_pkg::OP_MASK;
        end
        edso_pkg::A_IRQEN: begin
          n.irq_en = ((s.irq_en & ~bm[16:0]) | (n.wdata[16:0] & bm[16:0])) & edso_pkg::W1C;
        end
        default: n.bresp = edso_pkg::RESP_SLVERR;
      endcase
    end
    // flush is write-one-to-set; a fresh write beats the done strobe
    n.opmode[edso_pkg::OP_FLUSH] = (do_wr && n.awaddr == edso_pkg::A_OPMODE &&
      n.wdata[edso_pkg::OP_FLUSH] && bm[edso_pkg::OP_FLUSH]) ||
      (s.opmode[edso_pkg::OP_FLUSH] && !tx_fifo_flush_done);
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    // read channel: answer one cycle after the address is taken
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = edso_pkg::RESP_OKAY;
      case (s_axi_araddr)
        edso_pkg::A_STATUS: begin
          n.rdata = {6'h00, s.err_type, edso_pkg::proc_code(s.tx_st),
            edso_pkg::proc_code(s.rx_st), s.flags};
        end
        edso_pkg::A_OPMODE: n.rdata = s.opmode;
        edso_pkg::A_IRQEN: n.rdata = {15'h0000, s.irq_en};
        default: begin
          n.rdata = edso_pkg::RST_ZERO;
          n.rresp = edso_pkg::RESP_SLVERR;
        end
      endcase
    end
    n.arready = !n.rvalid;
    // bus error: the engine named by the error loses the bus until reset
    if (bus_err.valid) begin
      set[edso_pkg::FBI] = 1'b1;
      n.err_type = edso_pkg::be_code(bus_err);
      if (bus_err.tx) begin
        n.tx_bus_en = 1'b0;
      end else begin
        n.rx_bus_en = 1'b0;
      end
    end
    set[edso_pkg::ETI] = tx_frame_in_fifo;
    tx_run = s.opmode[edso_pkg::OP_TXGO] && s.tx_bus_en;
    rx_run = s.opmode[edso_pkg::OP_RXGO] && s.rx_bus_en;
    jab = tx_bytes > (jumbo_en ? edso_pkg::JAB_JUMBO : edso_pkg::JAB_STD);
    // transmit process
    case (s.tx_st)
      edso_pkg::PS_STOP: begin
        if (tx_run) begin
          n.tx_st = edso_pkg::PS_FETCH;
        end
      end
      edso_pkg::PS_FETCH: begin
        if (!tx_run) begin
          n.tx_st = edso_pkg::PS_STOP;
        end else if (tx_desc_valid) begin
          if (tx_desc_own) begin
            n.tx_st = edso_pkg::PS_XFER;
          end else begin
            n.tx_st = edso_pkg::PS_SUSP;
            set[edso_pkg::TU] = 1'b1;
          end
        end
      end
      edso_pkg::PS_SUSP: begin
        if (!tx_run) begin
          n.tx_st = edso_pkg::PS_STOP;
        end else if (tx_poll) begin
          n.tx_st = edso_pkg::PS_FETCH;
        end
      end
      edso_pkg::PS_XFER: begin
        // a cleared start bit is only honoured once the frame is over
        if (jab) begin
          n.tx_st = edso_pkg::PS_STOP;
          set[edso_pkg::TJT] = 1'b1;
          n.tx_wb = 1'b1;
          n.tx_word0 = edso_pkg::RST_ZERO;
          n.tx_word0[edso_pkg::D_JAB] = 1'b1;
        end else if (tx_underflow) begin
          n.tx_st = edso_pkg::PS_SUSP;
          set[edso_pkg::UNF] = 1'b1;
          n.tx_wb = 1'b1;
          n.tx_word0 = edso_pkg::RST_ZERO;
          n.tx_word0[edso_pkg::D_UNF] = 1'b1;
        end else if (tx_frame_done) begin
          n.tx_st = edso_pkg::PS_CLOSE;
          set[edso_pkg::TI] = 1'b1;
          n.tx_wb = 1'b1;
          n.tx_word0 = edso_pkg::RST_ZERO;
        end
      end
      edso_pkg::PS_CLOSE: n.tx_st = tx_run ? edso_pkg::PS_FETCH : edso_pkg::PS_STOP;
      default: n.tx_st = edso_pkg::PS_STOP;
    endcase
    if (!n.tx_bus_en) begin
      n.tx_st = edso_pkg::PS_STOP;
    end
    // receive process
    case (s.rx_st)
      edso_pkg::PS_STOP: begin
        if (rx_run) begin
          n.rx_st = edso_pkg::PS_FETCH;
        end
      end
      edso_pkg::PS_FETCH: begin
        if (!rx_run) begin
          n.rx_st = edso_pkg::PS_STOP;
        end else if (rx_desc_valid) begin
          n.rx_prev_own = rx_desc_own;
          if (rx_desc_own) begin
            n.rx_st = edso_pkg::PS_WAIT;
          end else begin
            n.rx_st = edso_pkg::PS_SUSP;
            set[edso_pkg::RU] = s.rx_prev_own;
            n.rx_flush = rx_fifo_whole && !s.opmode[edso_pkg::OP_NOFLUSH];
          end
        end
      end
      edso_pkg::PS_WAIT: begin
        if (!rx_run) begin
          n.rx_st = edso_pkg::PS_STOP;
        end else if (rx_frame_start) begin
          n.rx_st = edso_pkg::PS_XFER;
          n.rx_ovf_frame = 1'b0;
        end
      end
      edso_pkg::PS_SUSP: begin
        if (!rx_run) begin
          n.rx_st = edso_pkg::PS_STOP;
        end else if (rx_poll || rx_frame_start) begin
          n.rx_st = edso_pkg::PS_FETCH;
        end
      end
      edso_pkg::PS_XFER: begin
        set[edso_pkg::ERI] = rx_first_buf;
        if (rx_overflow) begin
          set[edso_pkg::OVF] = 1'b1;
          n.rx_ovf_frame = 1'b1;
        end
        if (rx_watchdog || rx_frame_done) begin
          n.rx_st = edso_pkg::PS_CLOSE;
          n.rx_trunc = rx_watchdog;
          set[edso_pkg::RWT] = rx_watchdog;
          set[edso_pkg::RXC] = !rx_int_disable;
          n.rx_wb = 1'b1;
          n.rx_word0 = edso_pkg::RST_ZERO;
          n.rx_word0[edso_pkg::D_OVF] = n.rx_ovf_frame;
        end
      end
      edso_pkg::PS_CLOSE: n.rx_st = rx_run ? edso_pkg::PS_FETCH : edso_pkg::PS_STOP;
      default: n.rx_st = edso_pkg::PS_STOP;
    endcase
    if (!n.rx_bus_en) begin
      n.rx_st = edso_pkg::PS_STOP;
    end
    set[edso_pkg::TPS] = (n.tx_st == edso_pkg::PS_STOP) && (s.tx_st != edso_pkg::PS_STOP);
    set[edso_pkg::RPS] = (n.rx_st == edso_pkg::PS_STOP) && (s.rx_st != edso_pkg::PS_STOP);
    // a set in the clearing cycle wins
    n.flags = (s.flags & ~clr) | set;
    if (set[edso_pkg::RXC]) begin
      n.flags[edso_pkg::ERI] = 1'b0;
    end
    n.flags[edso_pkg::NSUM] = (s.flags[edso_pkg::NSUM] && !clr[edso_pkg::NSUM]) ||
      (s.irq_en[edso_pkg::NSUM] && |(n.flags & s.irq_en & edso_pkg::NORM_SET));
    n.flags[edso_pkg::ASUM] = (s.flags[edso_pkg::ASUM] && !clr[edso_pkg::ASUM]) ||
      (s.irq_en[edso_pkg::ASUM] && |(n.flags & s.irq_en & edso_pkg::ABN_SET));
    n.rx_read_en = !s.opmode[edso_pkg::OP_RXSF] || rx_fifo_whole;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.tx_bus_en <= 1'b1;
      s.rx_bus_en <= 1'b1;
    end else begin
      s <= n;
    end
  end

  edso_frame_policy u_policy (
    .aclk(aclk),
    .aresetn(aresetn),
    .opmode(s.opmode),
    .rx_stat_valid(rx_stat_valid),
    .rx_stat(rx_stat),
    .tx_fifo_bytes(tx_fifo_bytes),
    .tx_frame_whole(tx_frame_in_fifo),
    .rx_verdict_valid(rx_verdict_valid),
    .rx_drop(rx_drop),
    .tx_go(tx_go)
  );

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign tx_bus_en = s.tx_bus_en;
  assign rx_bus_en = s.rx_bus_en;
  assign tx_desc_wr = s.tx_wb;
  assign tx_desc_word0 = s.tx_word0;
  assign rx_desc_wr = s.rx_wb;
  assign rx_desc_word0 = s.rx_word0;
  assign rx_truncate = s.rx_trunc;
  assign rx_flush = s.rx_flush;
  assign rx_read_en = s.rx_read_en;
  assign tx_fifo_flush = s.opmode[edso_pkg::OP_FLUSH];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_norm_sum;
    (s.irq_en[edso_pkg::NSUM] && |(s.flags & ~clr & s.irq_en & edso_pkg::NORM_SET))
      |=> s.flags[edso_pkg::NSUM];
  endproperty
  a_norm_sum: assert property (p_norm_sum) else $error("normal summary missing");

  property p_abn_sum;
    (!s.irq_en[edso_pkg::ASUM] && !s.flags[edso_pkg::ASUM]) |=> !s.flags[edso_pkg::ASUM];
  endproperty
  a_abn_sum: assert property (p_abn_sum) else $error("masked abnormal summary set");

  property p_sticky;
    (s.flags[edso_pkg::TI] && !clr[edso_pkg::TI]) |=> s.flags[edso_pkg::TI];
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky flag lost");

  property p_eri_clear;
    $rose(s.flags[edso_pkg::RXC]) |-> !s.flags[edso_pkg::ERI];
  endproperty
  a_eri_clear: assert property (p_eri_clear) else $error("early receive kept");

  property p_bus_halt;
    (bus_err.valid && bus_err.tx) |=> (!tx_bus_en && s.flags[edso_pkg::FBI]) ##1 !tx_bus_en[*4];
  endproperty
  a_bus_halt: assert property (p_bus_halt) else $error("tx bus not halted");

  property p_wdog;
    (s.rx_st == edso_pkg::PS_XFER && rx_watchdog && !bus_err.valid)
      |=> rx_truncate && s.flags[edso_pkg::RWT] && s.rx_st == edso_pkg::PS_CLOSE;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog truncation missing");

  property p_tx_stop;
    (s.tx_st != edso_pkg::PS_STOP) ##1 (s.tx_st == edso_pkg::PS_STOP) |-> s.flags[edso_pkg::TPS];
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("tx stopped flag missing");

  property p_rx_susp;
    (s.rx_st == edso_pkg::PS_FETCH && rx_run && rx_desc_valid && !rx_desc_own && !bus_err.valid)
      |=> s.rx_st == edso_pkg::PS_SUSP;
  endproperty
  a_rx_susp: assert property (p_rx_susp) else $error("rx did not suspend");

  property p_jab;
    (s.tx_st == edso_pkg::PS_XFER && jab && s.tx_bus_en)
      |=> tx_desc_wr && tx_desc_word0[edso_pkg::D_JAB] ##1 s.flags[edso_pkg::TPS];
  endproperty
  a_jab: assert property (p_jab) else $error("jabber not handled");

  property p_tx_done;
    (s.tx_st == edso_pkg::PS_XFER && tx_frame_done && !jab && !tx_underflow && s.tx_bus_en)
      |=> tx_desc_wr && !tx_desc_word0[edso_pkg::D_OWN] && s.flags[edso_pkg::TI];
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx completion missing");

  property p_rx_sf;
    (s.opmode[edso_pkg::OP_RXSF] && !rx_fifo_whole) |=> !rx_read_en;
  endproperty
  a_rx_sf: assert property (p_rx_sf) else $error("rx read before whole frame");

  c_tx_frame: cover property (s.tx_st == edso_pkg::PS_XFER ##1 s.tx_st == edso_pkg::PS_CLOSE);
  c_rx_susp: cover property (s.rx_st == edso_pkg::PS_SUSP ##1 s.rx_st == edso_pkg::PS_FETCH);
  c_bus_err: cover property (bus_err.valid ##1 s.flags[edso_pkg::FBI]);
  c_flush: cover property (tx_fifo_flush ##1 !tx_fifo_flush);
endmodule
`default_nettype wire

/* File: hdl/edso_frame_policy.sv */
// receive drop verdict and transmit start decision
`default_nettype none
module edso_frame_policy (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings
  input wire logic [31:0] opmode,
  // receive frame status
  input wire logic rx_stat_valid,
  input wire edso_pkg::edso_rxstat_s rx_stat,
  // transmit fifo fill
  input wire logic [13:0] tx_fifo_bytes,
  input wire logic tx_frame_whole,
  // decisions
  output logic rx_verdict_valid,
  output logic rx_drop,
  output logic tx_go
);
  typedef struct packed {
    logic vv;
    logic drop;
    logic go;
  } edso_pol_s;
  edso_pol_s s;
  edso_pol_s n;
  logic hard_err;

  always_comb begin
    hard_err = rx_stat.crc_err | rx_stat.coll_err | rx_stat.giant | rx_stat.wdog | rx_stat.ovf;
    n.vv = rx_stat_valid;
    n.drop = 1'b0;
    if (!opmode[edso_pkg::OP_FWDERR]) begin
      // checksum-only errors survive when the keep setting is on
      n.drop = hard_err | (rx_stat.csum_err & !opmode[edso_pkg::OP_CSUM]);
    end
    if (!hard_err && rx_stat.short_frame && !opmode[edso_pkg::OP_SHORT]) begin
      n.drop = 1'b1;
    end
    if (rx_stat.over_limit && opmode[edso_pkg::OP_OVERSZ]) begin
      n.drop = 1'b1;
    end
    if (opmode[edso_pkg::OP_TXSF]) begin
      n.go = tx_frame_whole;
    end else begin
      n.go = tx_frame_whole ||
        (tx_fifo_bytes > {5'h00, edso_pkg::tx_thresh(opmode[edso_pkg::OP_THR +: 3])});
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign rx_verdict_valid = s.vv;
  assign rx_drop = s.drop;
  assign tx_go = s.go;
endmodule
`default_nettype wire

/* File: hdl/edso_pkg.sv */
// constants, codes, types and helpers of the dma status and mode block
`default_nettype none
package edso_pkg;
  // register byte offsets
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_OPMODE = 8'h18;
  localparam logic [7:0] A_IRQEN = 8'h1c;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status flag positions
  localparam int TI = 0;
  localparam int TPS = 1;
  localparam int TU = 2;
  localparam int TJT = 3;
  localparam int OVF = 4;
  localparam int UNF = 5;
  localparam int RXC = 6;
  localparam int RU = 7;
  localparam int RPS = 8;
  localparam int RWT = 9;
  localparam int ETI = 10;
  localparam int FBI = 13;
  localparam int ERI = 14;
  localparam int ASUM = 15;
  localparam int NSUM = 16;
  localparam logic [16:0] NORM_SET = 17'h04045;
  localparam logic [16:0] ABN_SET = 17'h027ba;
  localparam logic [16:0] W1C = 17'h1e7ff;
  // operation mode positions
  localparam int OP_RXGO = 1;
  localparam int OP_SHORT = 3;
  localparam int OP_FWDERR = 4;
  localparam int OP_TXGO = 13;
  localparam int OP_THR = 14;
  localparam int OP_FLUSH = 20;
  localparam int OP_TXSF = 21;
  localparam int OP_OVERSZ = 22;
  localparam int OP_NOFLUSH = 24;
  localparam int OP_RXSF = 25;
  localparam int OP_CSUM = 26;
  localparam logic [31:0] OP_MASK = 32'h0771_e01a;
  // descriptor word0 positions
  localparam int D_OWN = 31;
  localparam int D_UNF = 1;
  localparam int D_OVF = 11;
  localparam int D_JAB = 14;
  // frame size limits in bytes
  localparam logic [13:0] JAB_STD = 14'd2048;
  localparam logic [13:0] JAB_JUMBO = 14'd10240;

  typedef enum logic [2:0] {PS_STOP, PS_FETCH, PS_WAIT, PS_SUSP, PS_CLOSE, PS_XFER} edso_proc_e;

  typedef struct packed {
    logic crc_err;
    logic coll_err;
    logic giant;
    logic wdog;
    logic ovf;
    logic csum_err;
    logic short_frame;
    logic over_limit;
  } edso_rxstat_s;

  typedef struct packed {
    logic valid;
    logic tx;
    logic desc;
    logic rd;
  } edso_buserr_s;

  function automatic logic [2:0] proc_code(input edso_proc_e st);
    case (st)
      PS_STOP: proc_code = 3'h0;
      PS_FETCH: proc_code = 3'h1;
      PS_WAIT: proc_code = 3'h3;
      PS_SUSP: proc_code = 3'h4;
      PS_CLOSE: proc_code = 3'h5;
      PS_XFER: proc_code = 3'h7;
      default: proc_code = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] be_code(input edso_buserr_s e);
    be_code = e.desc ? {1'b1, e.rd, e.tx} : {1'b0, e.tx, e.tx};
  endfunction

  function automatic logic [8:0] tx_thresh(input logic [2:0] c);
    case (c)
      3'h0: tx_thresh = 9'd64;
      3'h1: tx_thresh = 9'd128;
      3'h2: tx_thresh = 9'd192;
      3'h3: tx_thresh = 9'd256;
      3'h4: tx_thresh = 9'd40;
      3'h5: tx_thresh = 9'd32;
      3'h6: tx_thresh = 9'd24;
      default: tx_thresh = 9'd16;
    endcase
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction
endpackage
`default_nettype wire

/* File: test/edso_dma_status_tb.sv */
// self-checking bench for the dma status and mode block
`default_nettype none
module edso_dma_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 0, aresetn = 0, go = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, tx_desc_word0, rx_desc_word0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [13:0] tx_bytes = 0, tx_fifo_bytes = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tx_desc_valid, tx_desc_own, tx_frame_done;
  logic tx_poll = 0, tx_frame_in_fifo = 0, tx_underflow = 0, jumbo_en = 0;
  logic tx_fifo_flush_done = 0, rx_desc_valid = 0, rx_desc_own = 0, rx_poll = 0;
  logic rx_frame_start = 0, rx_first_buf = 0, rx_frame_done = 0, rx_int_disable = 0;
  logic rx_overflow = 0, rx_watchdog = 0, rx_fifo_whole = 0, rx_stat_valid = 0;
  edso_pkg::edso_rxstat_s rx_stat = '0;
  edso_pkg::edso_buserr_s bus_err = '0;
  logic tx_bus_en, rx_bus_en, tx_desc_wr, rx_desc_wr, rx_truncate, rx_flush, rx_read_en;
  logic tx_fifo_flush, tx_go, rx_verdict_valid, rx_drop;
  logic [65:0] rq[$];
  logic [65:0] e;
  logic [7:0] r;
  logic [31:0] dq[$], xq[$], vq[$];
  int err_total = 0, n_compared = 0, cyc = 0;
  int th[8] = '{64, 128, 192, 256, 40, 32, 24, 16};
  edso_dma_status i_dut (.*);
  edso_tx_engine_model i_eng (.*);
  always #12.5 aclk = ~aclk;
  task automatic results();
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    cmp({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, d, input logic [1:0] r);
    @(posedge aclk);
    rq.push_back({m, r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask
  // results are matched against the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      cmp(s_axi_rdata & e[65:34], e[31:0]);
      cmp({30'h0, s_axi_rresp}, {30'h0, e[33:32]});
    end
    if (tx_desc_wr) cmp(tx_desc_word0, dq.pop_front());
    if (rx_desc_wr) begin
      cmp(rx_desc_word0, xq.pop_front());
      cmp(32'(rx_truncate), xq.pop_front());
    end
    if (rx_verdict_valid) cmp(32'(rx_drop), vq.pop_front());
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      results();
    end
  end
  initial begin
    void'($urandom(32));
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(edso_pkg::A_STATUS, 32'hffffffff, 0, edso_pkg::RESP_OKAY);
    rd(edso_pkg::A_OPMODE, 32'hffffffff, 0, edso_pkg::RESP_OKAY);
    rd(8'h40, 32'hffffffff, 0, edso_pkg::RESP_SLVERR);
    wr(8'h40, 32'h1, edso_pkg::RESP_SLVERR);
    wr(edso_pkg::A_OPMODE, 32'h0000_2000, edso_pkg::RESP_OKAY);
    // first frame with the summary masked, second with it enabled
    for (int i = 0; i < 2; i++) begin
      wr(edso_pkg::A_IRQEN, i ? 32'h0001_0001 : 32'h0, edso_pkg::RESP_OKAY);
      dq.push_back(32'h0);
      @(posedge aclk) go <= 1;
      @(posedge aclk) go <= 0;
      repeat (8) @(posedge aclk);
      rd(edso_pkg::A_STATUS, 32'h0001ffff, {15'h0, i[0], 16'h1}, edso_pkg::RESP_OKAY);
      wr(edso_pkg::A_STATUS, 32'h0001_0001, edso_pkg::RESP_OKAY);
      rd(edso_pkg::A_STATUS, 32'h0001ffff, 0, edso_pkg::RESP_OKAY);
    end
    for (int i = 0; i < 8; i++) begin
      wr(edso_pkg::A_OPMODE, 32'(i) << 14, edso_pkg::RESP_OKAY);
      tx_fifo_bytes <= 14'($urandom_range(th[i]));
      repeat (3) @(posedge aclk);
      cmp(32'(tx_go), 0);
      tx_fifo_bytes <= 14'(th[i] + 1);
      repeat (3) @(posedge aclk);
      cmp(32'(tx_go), 1);
    end
    wr(edso_pkg::A_OPMODE, 32'h0020_0000, edso_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    cmp(32'(tx_go), 0);
    @(posedge aclk) tx_frame_in_fifo <= 1;
    @(posedge aclk) tx_frame_in_fifo <= 0;
    @(posedge aclk) cmp(32'(tx_go), 1);
    rd(edso_pkg::A_STATUS, 32'h400, 32'h400, edso_pkg::RESP_OKAY);
    wr(edso_pkg::A_OPMODE, 32'h0010_0000, edso_pkg::RESP_OKAY);
    cmp(32'(tx_fifo_flush), 1);
    @(posedge aclk) tx_fifo_flush_done <= 1;
    @(posedge aclk) tx_fifo_flush_done <= 0;
    repeat (2) @(posedge aclk);
    cmp(32'(tx_fifo_flush), 0);
    // one received frame cut by the watchdog, then a host-owned descriptor
    wr(edso_pkg::A_OPMODE, 32'h0600_0002, edso_pkg::RESP_OKAY);
    xq.push_back(32'h0000_0800);
    xq.push_back(32'h1);
    @(posedge aclk) {rx_desc_valid, rx_desc_own} <= 2'b11;
    @(posedge aclk) {rx_desc_valid, rx_frame_start} <= 2'b01;
    @(posedge aclk) {rx_frame_start, rx_first_buf, rx_overflow} <= 3'b011;
    @(posedge aclk) {rx_first_buf, rx_overflow, rx_watchdog} <= 3'b001;
    @(posedge aclk) rx_watchdog <= 0;
    cmp(32'(rx_read_en), 0);
    @(posedge aclk) {rx_desc_valid, rx_desc_own, rx_fifo_whole} <= 3'b101;
    @(posedge aclk) rx_desc_valid <= 0;
    @(posedge aclk) cmp(32'(rx_flush), 1);
    cmp(32'(rx_read_en), 1);
    rd(edso_pkg::A_STATUS, 32'h000e_42d0, 32'h0008_02d0, edso_pkg::RESP_OKAY);
    // hard errors and short frames go, checksum-only errors stay
    for (int k = 0; k < 8; k++) begin
      @(posedge aclk) rx_stat_valid <= 1;
      r = 8'($urandom);
      rx_stat <= r;
      vq.push_back(32'(|r[7:3] | r[1]));
    end
    @(posedge aclk) rx_stat_valid <= 0;
    // every engine and access kind, a fresh reset before each
    for (int i = 0; i < 8; i++) begin
      aresetn <= 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk) bus_err <= {1'b1, 3'(i)};
      @(posedge aclk) bus_err <= '0;
      rd(edso_pkg::A_STATUS, 32'h0380_2000,
         {6'h0, i[1], i[1] ? i[0] : i[2], i[2], 23'h2000}, edso_pkg::RESP_OKAY);
      cmp(32'(tx_bus_en), 32'(!i[2]));
      cmp(32'(rx_bus_en), 32'(i[2]));
    end
    results();
  end
endmodule
`default_nettype wire

/* File: test/edso_tx_engine_model.sv */
// transmit engine model: takes one host-released descriptor and sends one frame
`default_nettype none
module edso_tx_engine_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // frame request from the bench
  input wire logic go,
  // engine events
  output logic tx_desc_valid,
  output logic tx_desc_own,
  output logic tx_frame_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt <= 3'h0;
    else if (go) cnt <= 3'h1;
    else if (cnt != 3'h0) cnt <= cnt + 3'h1;
  end
  assign tx_desc_valid = (cnt == 3'h1);
  // host sets ownership before the poll; outside the fetch own toggles
  assign tx_desc_own = (cnt == 3'h1) | cnt[0];
  assign tx_frame_done = (cnt == 3'h4);
endmodule
`default_nettype wire
